/* File: rtl/csc_consts.svh */
// constants for the codec secondary command register block
// assumes byte-wide register port, 16-bit register addresses
//
// Function
// RULE1 - write transaction sends full eight-bit address register
// RULE2 - ac97 software loads seven-bit address, direction msb
// RULE3 - narrow mode: four address bits, direction bit 13
// RULE4 - software places direction and address per mode
// RULE5 - bit7 one requests read, zero write
// RULE6 - read overwrites address bits 6:0 from codec
// RULE7 - low data register holds command lsb
// RULE8 - high data register holds command msb
// RULE9 - read overwrites both data registers with status; the code does so only in ac97 modes, elsewhere only the low register
// RULE10 - gp and narrow modes use eight-bit data only
// RULE11 - valid flags 7:3 map slots 8-12
// RULE12 - valid flags take effect only in ac97 modes
// RULE13 - valid register bits 2:0 read zero
// RULE14 - codec select 00 primary, else secondary; the code selects secondary only in ac97 modes
// RULE15 - update registers only after whole status slot
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
`define CSC_ADDR_VSLL   16'hffd8
`define CSC_ADDR_DATH   16'hffd9
`define CSC_ADDR_DATL   16'hffda
`define CSC_ADDR_ADR    16'hffdb
`define CSC_RST_BYTE    8'h00
`define CSC_DIR_BIT     7
`define CSC_VSL_MASK    8'hf8
`endif

/* File: rtl/csc_pkg.sv */
// types for the codec secondary command register block
// assumes csc_consts.svh is compiled alongside
package csc_pkg;
    // codec port modes, gray coded
    typedef enum logic [2:0] {
        CSC_MODE_GP      = 3'b000,
        CSC_MODE_NARROW  = 3'b001,
        CSC_MODE_AC97    = 3'b011,
        CSC_MODE_AC97_2  = 3'b010,
        CSC_MODE_I2S     = 3'b110
    } csc_mode_type;
endpackage

/* File: rtl/csc_resp_latch.sv */
// holds a codec read response until the whole slot is in
// assumes the frame engine pulses done once per slot, same clock
`timescale 1ns/100ps
module csc_resp_latch (
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    input  wire logic        bit_valid_i,
    input  wire logic        bit_i,
    input  wire logic        slot_done_i,
    output logic [15:0]      word_o,
    output logic             word_valid_o
);
    logic [15:0] shift_q;
    logic [15:0] word_q;
    logic        valid_q;

    // msb-first shift of the incoming status bits
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            shift_q <= 16'h0000;
        end else if (bit_valid_i) begin
            shift_q <= {shift_q[14:0], bit_i};
        end
    end

    // word is published only at slot end, never partially [RULE15]
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            word_q  <= 16'h0000;
            valid_q <= 1'b0;
        end else begin
            valid_q <= slot_done_i;
            if (slot_done_i) begin
                word_q <= shift_q;
            end
        end
    end

    assign word_o       = word_q;
    assign word_valid_o = valid_q;
endmodule

/* File: rtl/csc_regs.sv */
// codec secondary command registers: address, data, valid slots
// assumes a byte register port and a frame engine on mclk_i
`timescale 1ns/100ps
`include "csc_consts.svh"
module csc_regs
    import csc_pkg::*;
(
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    input  wire logic [15:0]  reg_addr_i,
    input  wire logic [7:0]   reg_wdata_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    output logic [7:0]        reg_rdata_o,
    input  wire csc_mode_type mode_i,
    input  wire logic [1:0]   codec_target_select_i,
    input  wire logic         st_bit_valid_i,
    input  wire logic         st_bit_i,
    input  wire logic         st_slot_done_i,
    input  wire logic [6:0]   st_addr_i,
    input  wire logic         st_addr_valid_i,
    output logic [7:0]        tx_addr_o,
    output logic [15:0]       tx_data_o,
    output logic              tx_read_o,
    output logic              tx_secondary_o,
    output logic [4:0]        slot_valid_flags_o
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0]  command_address_reg_q;
    logic [7:0]  command_data_low_reg_q;
    logic [7:0]  command_data_high_reg_q;
    logic [4:0]  valid_slot_low_reg_q;
    logic [7:0]  rdata_q;
    logic [15:0] resp_word;
    logic        resp_valid;
    logic        is_ac97;
    logic        addr_pending_q;
    logic [6:0]  addr_hold_q;

    assign is_ac97 = (mode_i == CSC_MODE_AC97) ||
                     (mode_i == CSC_MODE_AC97_2);

    csc_resp_latch u_resp (
        .mclk_i       (mclk_i),
        .nrst_i       (nrst_i),
        .bit_valid_i  (st_bit_valid_i),
        .bit_i        (st_bit_i),
        .slot_done_i  (st_slot_done_i),
        .word_o       (resp_word),
        .word_valid_o (resp_valid)
    );

    ////////////////////////////////////////////////////////////////////
    // returned address is held until its status slot has completed,
    // so address and data land together
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            addr_pending_q <= 1'b0;
            addr_hold_q    <= 7'h00;
        end else if (st_addr_valid_i) begin
            addr_pending_q <= 1'b1;
            addr_hold_q    <= st_addr_i;
        end else if (resp_valid) begin
            addr_pending_q <= 1'b0;
        end
    end

    // direction bit stays software-owned; hardware only replaces 6:0
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            command_address_reg_q <= `CSC_RST_BYTE;
        end else if (resp_valid && tx_read_o && addr_pending_q) begin
            command_address_reg_q[6:0] <= addr_hold_q; // [RULE6] [RULE15]
        end else if (reg_wr_i && reg_addr_i == `CSC_ADDR_ADR) begin
            command_address_reg_q <= reg_wdata_i; // [RULE4] [RULE5]
        end
    end

    // hardware update wins over a same-cycle software write
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            command_data_low_reg_q <= `CSC_RST_BYTE;
        end else if (resp_valid && tx_read_o) begin
            if (is_ac97) begin
                command_data_low_reg_q <= resp_word[7:0]; // [RULE9]
            end else begin
                command_data_low_reg_q <= resp_word[15:8]; // [RULE10]
            end
        end else if (reg_wr_i && reg_addr_i == `CSC_ADDR_DATL) begin
            command_data_low_reg_q <= reg_wdata_i; // [RULE7]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            command_data_high_reg_q <= `CSC_RST_BYTE;
        end else if (resp_valid && tx_read_o && is_ac97) begin
            command_data_high_reg_q <= resp_word[15:8]; // [RULE9] [RULE10]
        end else if (reg_wr_i && reg_addr_i == `CSC_ADDR_DATH) begin
            command_data_high_reg_q <= reg_wdata_i; // [RULE8]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            valid_slot_low_reg_q <= 5'h00;
        end else if (reg_wr_i && reg_addr_i == `CSC_ADDR_VSLL) begin
            valid_slot_low_reg_q <= reg_wdata_i[7:3]; // [RULE11]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rdata_q <= 8'h00;
        end else if (!reg_rd_i) begin
            rdata_q <= 8'h00;
        end else if (reg_addr_i == `CSC_ADDR_VSLL) begin
            rdata_q <= {valid_slot_low_reg_q, 3'h0}; // [RULE13]
        end else if (reg_addr_i == `CSC_ADDR_DATH) begin
            rdata_q <= command_data_high_reg_q;
        end else if (reg_addr_i == `CSC_ADDR_DATL) begin
            rdata_q <= command_data_low_reg_q;
        end else if (reg_addr_i == `CSC_ADDR_ADR) begin
            rdata_q <= command_address_reg_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // toward the frame engine
    assign tx_addr_o = command_address_reg_q; // [RULE1]
    assign tx_read_o = command_address_reg_q[`CSC_DIR_BIT]; // [RULE5]
    // narrow and gp modes carry only the low byte [RULE10]
    assign tx_data_o = is_ac97 ?
        {command_data_high_reg_q, command_data_low_reg_q} :
        {8'h00, command_data_low_reg_q};
    // the select only means something where a second codec can sit
    assign tx_secondary_o = is_ac97 &&
                            (codec_target_select_i != 2'b00); // [RULE14]

    // one gate per slot flag, bit 4 is slot 8 and bit 0 is slot 12;
    // outside ac97 the frame has no such slots, so software's flags
    // are kept but never reach the frame engine
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_slot
            assign slot_valid_flags_o[gi] = is_ac97 &&
                valid_slot_low_reg_q[gi]; // [RULE12]
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, zero otherwise
    read_lat_a: assert property ( // [RULE4]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == `CSC_ADDR_ADR |=>
        reg_rdata_o == $past(command_address_reg_q))
        else $error("address read data wrong");

    read_datl_a: assert property ( // [RULE7]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == `CSC_ADDR_DATL |=>
        reg_rdata_o == $past(command_data_low_reg_q))
        else $error("low data read wrong");

    read_dath_a: assert property ( // [RULE8]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == `CSC_ADDR_DATH |=>
        reg_rdata_o == $past(command_data_high_reg_q))
        else $error("high data read wrong");

    read_vsl_a: assert property ( // [RULE11]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_rd_i && reg_addr_i == `CSC_ADDR_VSLL |=>
        reg_rdata_o[7:3] == $past(valid_slot_low_reg_q))
        else $error("valid flags read wrong");

    vsl_zero_a: assert property ( // [RULE13]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_rdata_o[2:0] == 3'h0 || $past(reg_addr_i) != `CSC_ADDR_VSLL)
        else $error("reserved bits not zero");

    rd_idle_a: assert property ( // [RULE4]
        @(posedge mclk_i) disable iff (!nrst_i)
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data left standing");

    rd_unmapped_a: assert property ( // [RULE13]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_rd_i && (reg_addr_i < `CSC_ADDR_VSLL ||
            reg_addr_i > `CSC_ADDR_ADR) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");

    ////////////////////////////////////////////////////////////////////
    // software writes land one cycle later unless hardware owns the cycle
    tx_addr_a: assert property ( // [RULE1]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_wr_i && reg_addr_i == `CSC_ADDR_ADR && !resp_valid |=>
        tx_addr_o == $past(reg_wdata_i))
        else $error("address byte not sent whole");

    wr_low_a: assert property ( // [RULE7]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_wr_i && reg_addr_i == `CSC_ADDR_DATL &&
        !(resp_valid && tx_read_o) |=>
        command_data_low_reg_q == $past(reg_wdata_i))
        else $error("low data write lost");

    wr_high_a: assert property ( // [RULE8]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_wr_i && reg_addr_i == `CSC_ADDR_DATH &&
        !(resp_valid && tx_read_o && is_ac97) |=>
        command_data_high_reg_q == $past(reg_wdata_i))
        else $error("high data write lost");

    wr_vsl_a: assert property ( // [RULE11]
        @(posedge mclk_i) disable iff (!nrst_i)
        reg_wr_i && reg_addr_i == `CSC_ADDR_VSLL |=>
        valid_slot_low_reg_q == $past(reg_wdata_i[7:3]))
        else $error("valid flags write lost");

    dir_keep_a: assert property ( // [RULE5]
        @(posedge mclk_i) disable iff (!nrst_i)
        !(reg_wr_i && reg_addr_i == `CSC_ADDR_ADR) |=>
        $stable(command_address_reg_q[`CSC_DIR_BIT]))
        else $error("direction bit moved by hardware");

    ////////////////////////////////////////////////////////////////////
    // what the frame engine is shown in each mode
    slot_gate_a: assert property ( // [RULE12]
        @(posedge mclk_i) disable iff (!nrst_i)
        !is_ac97 |-> slot_valid_flags_o == 5'h00)
        else $error("valid flags leak outside ac97");

    slot_pass_a: assert property ( // [RULE11]
        @(posedge mclk_i) disable iff (!nrst_i)
        is_ac97 |-> slot_valid_flags_o == valid_slot_low_reg_q)
        else $error("valid flags not passed in ac97");

    sec_sel_a: assert property ( // [RULE14]
        @(posedge mclk_i) disable iff (!nrst_i)
        is_ac97 && codec_target_select_i == 2'b00 |-> !tx_secondary_o)
        else $error("primary codec not selected");

    sec_other_a: assert property ( // [RULE14]
        @(posedge mclk_i) disable iff (!nrst_i)
        is_ac97 && codec_target_select_i != 2'b00 |-> tx_secondary_o)
        else $error("secondary codec not selected");

    sec_off_a: assert property ( // [RULE14]
        @(posedge mclk_i) disable iff (!nrst_i)
        !is_ac97 |-> !tx_secondary_o)
        else $error("secondary codec outside ac97");

    narrow_a: assert property ( // [RULE10]
        @(posedge mclk_i) disable iff (!nrst_i)
        !is_ac97 |-> tx_data_o[15:8] == 8'h00)
        else $error("high byte sent in narrow mode");

    wide_data_a: assert property ( // [RULE8]
        @(posedge mclk_i) disable iff (!nrst_i)
        is_ac97 |->
        tx_data_o == {command_data_high_reg_q, command_data_low_reg_q})
        else $error("ac97 data word not whole");

    ////////////////////////////////////////////////////////////////////
    // status responses, applied only once the whole slot is in
    data_hi_a: assert property ( // [RULE9]
        @(posedge mclk_i) disable iff (!nrst_i)
        resp_valid && tx_read_o && is_ac97 |=>
        command_data_high_reg_q == $past(resp_word[15:8]))
        else $error("high status byte not stored");

    data_lo_a: assert property ( // [RULE9]
        @(posedge mclk_i) disable iff (!nrst_i)
        resp_valid && tx_read_o && is_ac97 |=>
        command_data_low_reg_q == $past(resp_word[7:0]))
        else $error("low status byte not stored");

    narrow_lo_a: assert property ( // [RULE10]
        @(posedge mclk_i) disable iff (!nrst_i)
        resp_valid && tx_read_o && !is_ac97 |=>
        command_data_low_reg_q == $past(resp_word[15:8]))
        else $error("narrow status byte not stored");

    narrow_hi_a: assert property ( // [RULE10]
        @(posedge mclk_i) disable iff (!nrst_i)
        resp_valid && tx_read_o && !is_ac97 && !reg_wr_i |=>
        $stable(command_data_high_reg_q))
        else $error("high byte touched in narrow mode");

    wr_ignore_a: assert property ( // [RULE5]
        @(posedge mclk_i) disable iff (!nrst_i)
        resp_valid && !tx_read_o && !reg_wr_i |=>
        $stable(command_data_low_reg_q) &&
        $stable(command_data_high_reg_q))
        else $error("response taken on a write");

    addr_read_a: assert property ( // [RULE6]
        @(posedge mclk_i) disable iff (!nrst_i)
        resp_valid && tx_read_o && addr_pending_q |=>
        command_address_reg_q == {1'b1, $past(addr_hold_q)})
        else $error("returned address not stored");

    pending_set_a: assert property ( // [RULE6]
        @(posedge mclk_i) disable iff (!nrst_i)
        st_addr_valid_i |=> addr_pending_q)
        else $error("returned address not held");

    addr_keep_a: assert property ( // [RULE15]
        @(posedge mclk_i) disable iff (!nrst_i)
        !resp_valid && !reg_wr_i |=> $stable(command_address_reg_q))
        else $error("address changed mid slot");

    data_keep_a: assert property ( // [RULE15]
        @(posedge mclk_i) disable iff (!nrst_i)
        !resp_valid && !reg_wr_i |=>
        $stable(command_data_low_reg_q) &&
        $stable(command_data_high_reg_q))
        else $error("data changed mid slot");

    resp_slot_a: assert property ( // [RULE15]
        @(posedge mclk_i) disable iff (!nrst_i)
        resp_valid |-> $past(st_slot_done_i))
        else $error("response without slot end");

    latch_hold_a: assert property ( // [RULE15]
        @(posedge mclk_i) disable iff (!nrst_i)
        !st_slot_done_i |=> $stable(resp_word))
        else $error("status word moved mid slot");
endmodule

/* File: tb/csc_codec_model.sv */
// behavioural codec: returns one status slot per call of send
// assumes the caller enters send right after a rising edge of mclk_i
`timescale 1ns/100ps
module csc_codec_model (
    input  wire logic       mclk_i,
    output logic            bit_valid_o  = 1'b0,
    output logic            bit_o        = 1'b0,
    output logic            slot_done_o  = 1'b0,
    output logic [6:0]      addr_o       = 7'h00,
    output logic            addr_valid_o = 1'b0
);
    ////////////////////////////////////////////////////////////////////////
    task automatic send(input logic [6:0] a, input logic [15:0] d);
        addr_o       <= a;
        addr_valid_o <= 1'b1;
        @(posedge mclk_i);
        addr_valid_o <= 1'b0;
        // released lines show the inverse so stale values cannot pass
        addr_o       <= ~a;
        for (int i = 15; i >= 0; i--) begin
            bit_valid_o <= 1'b1;
            bit_o       <= d[i];
            @(posedge mclk_i);
        end
        bit_valid_o <= 1'b0;
        bit_o       <= ~d[0];
        slot_done_o <= 1'b1;
        @(posedge mclk_i);
        slot_done_o <= 1'b0;
    endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the codec secondary command registers
// assumes csc_codec_model stands in for the codec status path
`timescale 1ns/100ps
`include "csc_consts.svh"
module tb import csc_pkg::*;;
    logic         mclk_i      = 1'b0;
    logic         nrst_i      = 1'b0;
    logic [15:0]  reg_addr_i  = 16'h0000;
    logic [7:0]   reg_wdata_i = 8'h00;
    logic         reg_wr_i    = 1'b0;
    logic         reg_rd_i    = 1'b0;
    csc_mode_type mode_i      = CSC_MODE_AC97;
    logic [1:0]   sel         = 2'h0;
    logic [7:0]   reg_rdata_o, tx_addr_o;
    logic [15:0]  tx_data_o;
    logic         tx_read_o, tx_secondary_o, bv, bt, sd, av;
    logic [4:0]   slot_valid_flags_o;
    logic [6:0]   sa;
    int           fail_count  = 0;
    int           comparisons = 0;
    int           cycles      = 0;
    csc_regs i_csc_regs (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .mode_i(mode_i), .codec_target_select_i(sel), .st_bit_valid_i(bv),
        .st_bit_i(bt), .st_slot_done_i(sd), .st_addr_i(sa),
        .st_addr_valid_i(av), .tx_addr_o(tx_addr_o), .tx_data_o(tx_data_o),
        .tx_read_o(tx_read_o), .tx_secondary_o(tx_secondary_o),
        .slot_valid_flags_o(slot_valid_flags_o));
    csc_codec_model i_csc_codec_model (.mclk_i(mclk_i), .bit_valid_o(bv),
        .bit_o(bt), .slot_done_o(sd), .addr_o(sa), .addr_valid_o(av));
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
        #1 chk({8'h00, reg_rdata_o}, {8'h00, e});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(`CSC_ADDR_ADR, 8'h00);
        rd(`CSC_ADDR_DATL, 8'h00);
        rd(`CSC_ADDR_DATH, 8'h00);
        rd(`CSC_ADDR_VSLL, 8'h00);
        rd(16'hffd0, 8'h00);
        wr(`CSC_ADDR_ADR, 8'h3c);
        chk({8'h00, tx_addr_o}, 16'h003c);
        chk({15'h0, tx_read_o}, 16'h0000);
        wr(`CSC_ADDR_DATL, 8'ha5);
        wr(`CSC_ADDR_DATH, 8'h5a);
        wr(`CSC_ADDR_VSLL, 8'hc7);
        wr(16'hffd0, 8'hff);
        rd(`CSC_ADDR_VSLL, 8'hc0);
        chk(tx_data_o, 16'h5aa5);
        chk({11'h0, slot_valid_flags_o}, 16'h0018);
        $display("test regs done");
    endtask
    task automatic t_modes();
        csc_mode_type m [5] = '{CSC_MODE_GP, CSC_MODE_NARROW, CSC_MODE_AC97,
                                CSC_MODE_AC97_2, CSC_MODE_I2S};
        logic ac;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            mode_i <= m[i/4];
            sel    <= 2'(i);
            @(posedge mclk_i);
            #1 ac = (m[i/4] == CSC_MODE_AC97) || (m[i/4] == CSC_MODE_AC97_2);
            chk({15'h0, tx_secondary_o}, {15'h0, ac && (i%4 != 0)});
            chk({11'h0, slot_valid_flags_o}, ac ? 16'h18 : 16'h0);
            chk(tx_data_o, ac ? 16'h5aa5 : 16'h00a5);
        end
        $display("test modes done");
    endtask
    task automatic t_status(input csc_mode_type m, input logic [7:0] a,
                            input logic [15:0] d, input logic [15:0] e);
        @(posedge mclk_i);
        mode_i <= m;
        wr(`CSC_ADDR_ADR, a);
        chk({15'h0, tx_read_o}, {15'h0, a[7]});
        i_csc_codec_model.send(7'h2a, d);
        // e is the tx_data_o word shown before this slot's response lands
        #1 chk(tx_data_o, e);
        chk({8'h00, tx_addr_o}, {8'h00, a});
        repeat (2) @(posedge mclk_i);
        #1;
    endtask
    task automatic t_read();
        t_status(CSC_MODE_AC97, 8'h92, 16'hbeef, 16'h5aa5);
        chk(tx_data_o, 16'hbeef);
        rd(`CSC_ADDR_ADR, 8'haa);
        rd(`CSC_ADDR_DATL, 8'hef);
        rd(`CSC_ADDR_DATH, 8'hbe);
        t_status(CSC_MODE_NARROW, 8'h91, 16'h3c77, 16'h00ef);
        rd(`CSC_ADDR_DATL, 8'h3c);
        rd(`CSC_ADDR_DATH, 8'hbe);
        t_status(CSC_MODE_GP, 8'h05, 16'h1234, 16'h003c);
        rd(`CSC_ADDR_DATL, 8'h3c);
        rd(`CSC_ADDR_ADR, 8'h05);
        chk({8'h00, tx_addr_o}, 16'h0005);
        $display("test status done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_regs();
        t_modes();
        t_read();
        finish_test();
    end
endmodule
